// ---- design/cdvdc_pkg.sv ----
package cdvdc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 16;
  localparam int          IDX_W    = 14;
  localparam logic [13:0] IDX_CNT  = 14'h0196;
  localparam logic [13:0] IDX_CTL  = 14'h0197;
  localparam logic [13:0] IDX_RT   = 14'h0198;
  localparam logic [13:0] IDX_SDV  = 14'h01E0;
  localparam logic [13:0] IDX_SEL  = 14'h01E1;
  localparam logic [13:0] IDX_SYS  = 14'h0230;
  localparam logic [13:0] IDX_UPD  = 14'h0232;
  localparam logic [13:0] IDX_STAT = 14'h0233;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CNT_W        = 4;
  localparam int LOW_LSB      = 4;
  localparam int HIGH_LSB     = 0;
  localparam int CTL_BYPASS   = 7;
  localparam int CTL_NOSYNC   = 6;
  localparam int CTL_FORCE    = 5;
  localparam int CTL_START    = 4;
  localparam int PH_LSB       = 0;
  localparam int RT_DIRECT    = 1;
  localparam int RT_DCC_OFF   = 0;
  localparam int SDV_LSB      = 0;
  localparam int SDV_W        = 3;
  localparam int SEL_PD_SECT  = 4;
  localparam int SEL_PD_OIF   = 3;
  localparam int SEL_PD_IN    = 2;
  localparam int SEL_OSC      = 1;
  localparam int SEL_BYP      = 0;
  localparam int SYS_SOFT     = 0;
  localparam int UPD_BIT      = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CNT  = 8'h00;
  localparam logic [7:0] RST_CTL  = 8'h00;
  localparam logic [7:0] RST_RT   = 8'h00;
  localparam logic [7:0] RST_SDV  = 8'h02;
  localparam logic [7:0] RST_SEL  = 8'h00;
  localparam logic [7:0] RST_SYS  = 8'h00;
  localparam logic [2:0] SDV_MAX  = 3'h4;
  localparam logic [2:0] SDV_BASE = 3'h2;
  localparam logic [1:0] RT_OSC   = 2'h2;
  localparam logic [1:0] RT_EXT   = 2'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h1,
    ST_DELAY = 3'h2,
    ST_RUN   = 3'h4
  } cdvdc_state_t;

endpackage

// ---- design/cdvdc_chan_div.sv ----
`timescale 1ns/1ps
module cdvdc_chan_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       in_lvl,
  input  wire logic       in_tick,
  input  wire logic       hold,
  input  wire logic       start_hi,
  input  wire logic       dcc_on,
  input  wire logic       bypass,
  input  wire logic [3:0] low_cnt,
  input  wire logic [3:0] high_cnt,
  input  wire logic [3:0] phase,
  output logic            div_out,
  output logic            running
);

  cdvdc_pkg::cdvdc_state_t state_q;
  logic [3:0]              cnt_q;
  logic                    lvl_q;

  // Period split, balanced halves while correction is on
  wire [4:0] total  = 5'({1'b0, low_cnt}) + 5'({1'b0, high_cnt}) + 5'h02;
  wire [4:0] hi_bal = total >> 1;
  wire [3:0] hi_m1  = dcc_on ? 4'(hi_bal - 5'h01) : high_cnt;
  wire [3:0] lo_m1  = dcc_on ? 4'(total - hi_bal - 5'h01) : low_cnt;
  wire [3:0] first  = start_hi ? hi_m1 : lo_m1;

  // Hold, phase delay and run sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cdvdc_pkg::ST_HOLD;
      cnt_q   <= '0;
      lvl_q   <= 1'b0;
    end else if (hold) begin
      state_q <= cdvdc_pkg::ST_HOLD;
      lvl_q   <= start_hi;
      cnt_q   <= phase;
    end else begin
      unique case (state_q)
        cdvdc_pkg::ST_HOLD: begin
          if (cnt_q == '0) begin
            state_q <= cdvdc_pkg::ST_RUN;
            cnt_q   <= first;
          end else begin
            state_q <= cdvdc_pkg::ST_DELAY;
          end
        end
        cdvdc_pkg::ST_DELAY: begin
          if (in_tick && cnt_q == 4'h1) begin
            state_q <= cdvdc_pkg::ST_RUN;
            lvl_q   <= start_hi;
            cnt_q   <= first;
          end else if (in_tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        cdvdc_pkg::ST_RUN: begin
          if (in_tick && cnt_q == '0) begin
            lvl_q <= !lvl_q;
            cnt_q <= lvl_q ? lo_m1 : hi_m1;
          end else if (in_tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= cdvdc_pkg::ST_HOLD;
      endcase
    end
  end

  assign div_out = bypass ? in_lvl : lvl_q;
  assign running = state_q == cdvdc_pkg::ST_RUN;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CH_BYPASS: assert property (bypass |-> div_out == in_lvl)
    else $error("bypassed divider does not follow its input");
  AST_CH_START: assert property (hold |=> lvl_q == $past(start_hi))
    else $error("held divider not at start level");
  AST_CH_COUNT: assert property (
    running && in_tick && cnt_q != '0 && !hold |=> $stable(lvl_q))
    else $error("divider toggled before count expired");

endmodule

// ---- design/cdvdc_top.sv ----
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module cdvdc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        sync_n,
  input  wire logic        osc_clk_in,
  input  wire logic        ext_clk_in,
  output logic             pair_two_output_a,
  output logic             pair_two_output_b
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] osc_ff_q;
  logic [1:0] ext_ff_q;
  logic [1:0] syn_ff_q;

  // Two flops per pin; only the second stage is used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ff_q <= '0;
      ext_ff_q <= '0;
      syn_ff_q <= 2'h3;
    end else begin
      osc_ff_q <= {osc_ff_q[0], osc_clk_in};
      ext_ff_q <= {ext_ff_q[0], ext_clk_in};
      syn_ff_q <= {syn_ff_q[0], sync_n};
    end
  end

  wire osc_s = osc_ff_q[1];
  wire ext_s = ext_ff_q[1];
  wire syn_s = syn_ff_q[1];

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a,
                               input logic [13:0] idx);
    return a == {idx, 2'h0};
  endfunction

  logic        aw_full_q;
  logic        w_full_q;
  logic [15:0] awaddr_q;
  logic [7:0]  wbyte_q;
  logic        wen_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // Address and data are taken in either order, one write at a time
  assign awready = !aw_full_q && !bvalid_q;
  assign wready  = !w_full_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
  wire w_cnt   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_CNT);
  wire w_ctl   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_CTL);
  wire w_rt    = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_RT);
  wire w_sdv   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_SDV);
  wire w_sel   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_SEL);
  wire w_sys   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_SYS);
  wire w_upd   = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_UPD);
  wire w_stat  = wr_fire && hit(awaddr_q, cdvdc_pkg::IDX_STAT);
  wire w_map   = w_cnt || w_ctl || w_rt || w_sdv || w_sel || w_sys
                 || w_upd || w_stat;
  wire upd     = w_upd && wen_q && wbyte_q[cdvdc_pkg::UPD_BIT];

  // Write address holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  // Write data holding register, low lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wbyte_q  <= '0;
      wen_q    <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      wbyte_q  <= wdata[7:0];
      wen_q    <= wstrb[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= cdvdc_pkg::RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= w_map ? cdvdc_pkg::RESP_OK : cdvdc_pkg::RESP_ERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Buffer and active register sets
  // ----------------------------------------------------------------
  logic [7:0] b_cnt_q, b_ctl_q, b_rt_q, b_sdv_q, b_sel_q, b_sys_q;
  logic [7:0] a_cnt_q, a_ctl_q, a_rt_q, a_sdv_q, a_sel_q, a_sys_q;

  // Software writes land in the buffer set only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_cnt_q <= cdvdc_pkg::RST_CNT;
      b_ctl_q <= cdvdc_pkg::RST_CTL;
      b_rt_q  <= cdvdc_pkg::RST_RT;
      b_sdv_q <= cdvdc_pkg::RST_SDV;
      b_sel_q <= cdvdc_pkg::RST_SEL;
      b_sys_q <= cdvdc_pkg::RST_SYS;
    end else if (wen_q) begin
      if (w_cnt) b_cnt_q <= wbyte_q;
      if (w_ctl) b_ctl_q <= wbyte_q;
      if (w_rt)  b_rt_q  <= wbyte_q;
      if (w_sdv) b_sdv_q <= wbyte_q;
      if (w_sel) b_sel_q <= wbyte_q;
      if (w_sys) b_sys_q <= wbyte_q;
    end
  end

  // Update copies the whole buffer set at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_cnt_q <= cdvdc_pkg::RST_CNT;
      a_ctl_q <= cdvdc_pkg::RST_CTL;
      a_rt_q  <= cdvdc_pkg::RST_RT;
      a_sdv_q <= cdvdc_pkg::RST_SDV;
      a_sel_q <= cdvdc_pkg::RST_SEL;
      a_sys_q <= cdvdc_pkg::RST_SYS;
    end else if (upd) begin
      a_cnt_q <= b_cnt_q;
      a_ctl_q <= b_ctl_q;
      a_rt_q  <= b_rt_q;
      a_sdv_q <= b_sdv_q;
      a_sel_q <= b_sel_q;
      a_sys_q <= b_sys_q;
    end
  end

  // ----------------------------------------------------------------
  // Field decode from the active set
  // ----------------------------------------------------------------
  wire       ch_byp    = a_ctl_q[cdvdc_pkg::CTL_BYPASS];
  wire       nosync    = a_ctl_q[cdvdc_pkg::CTL_NOSYNC];
  wire       force_hi  = a_ctl_q[cdvdc_pkg::CTL_FORCE];
  wire       start_hi  = a_ctl_q[cdvdc_pkg::CTL_START];
  wire [3:0] phase     = a_ctl_q[cdvdc_pkg::PH_LSB +: cdvdc_pkg::CNT_W];
  wire [3:0] low_cnt   = a_cnt_q[cdvdc_pkg::LOW_LSB +: cdvdc_pkg::CNT_W];
  wire [3:0] high_cnt  = a_cnt_q[cdvdc_pkg::HIGH_LSB +: cdvdc_pkg::CNT_W];
  wire       direct    = a_rt_q[cdvdc_pkg::RT_DIRECT];
  wire       dcc_off   = a_rt_q[cdvdc_pkg::RT_DCC_OFF];
  wire [2:0] sdv_code  = a_sdv_q[cdvdc_pkg::SDV_LSB +: cdvdc_pkg::SDV_W];
  wire       pd_sect   = a_sel_q[cdvdc_pkg::SEL_PD_SECT];
  wire       pd_oif    = a_sel_q[cdvdc_pkg::SEL_PD_OIF];
  wire       pd_in     = a_sel_q[cdvdc_pkg::SEL_PD_IN];
  wire       sel_osc   = a_sel_q[cdvdc_pkg::SEL_OSC];
  wire       src_byp   = a_sel_q[cdvdc_pkg::SEL_BYP];
  wire [1:0] rt_code   = {sel_osc, src_byp};
  wire       soft_sync = a_sys_q[cdvdc_pkg::SYS_SOFT];

  // ----------------------------------------------------------------
  // Clock source selection and source divider
  // ----------------------------------------------------------------
  logic       src_prev_q;
  logic       dist_prev_q;
  logic [2:0] sdv_cnt_q;
  logic       sdv_lvl_q;

  // Power-down gating of the two sources
  wire osc_lvl = osc_s && !pd_in && !pd_oif;
  wire ext_lvl = ext_s && !pd_in;
  wire src_lvl = !pd_sect && (sel_osc ? osc_lvl : ext_lvl);
  wire src_rise = src_lvl && !src_prev_q;

  // Ratio is code plus two; upper codes stop the divider
  wire [2:0] ratio      = sdv_code + cdvdc_pkg::SDV_BASE;
  wire       sdv_static = sdv_code > cdvdc_pkg::SDV_MAX;
  wire [2:0] sdv_nxt    = (sdv_cnt_q >= ratio - 3'h1) ? 3'h0
                          : sdv_cnt_q + 3'h1;
  wire       byp_eff    = src_byp && !sel_osc;
  wire       dist_lvl   = !pd_sect && (byp_eff ? src_lvl : sdv_lvl_q);
  wire       dist_rise  = dist_lvl && !dist_prev_q;

  // Edge history of source and distribution levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q  <= 1'b0;
      dist_prev_q <= 1'b0;
    end else begin
      src_prev_q  <= src_lvl;
      dist_prev_q <= dist_lvl;
    end
  end

  // Source divider counts source rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdv_cnt_q <= '0;
      sdv_lvl_q <= 1'b0;
    end else if (sdv_static || pd_sect) begin
      sdv_cnt_q <= '0;
      sdv_lvl_q <= 1'b0;
    end else if (src_rise) begin
      sdv_cnt_q <= sdv_nxt;
      sdv_lvl_q <= sdv_nxt < (ratio >> 1);
    end
  end

  // ----------------------------------------------------------------
  // Channel two divider and output routing
  // ----------------------------------------------------------------
  logic ch_out;
  logic ch_run;
  logic out_q;

  // Pin low or soft bit high holds; release is the sync event
  wire sync_hold = !syn_s || soft_sync;
  wire ch_hold   = (!nosync && sync_hold) || pd_sect;

  cdvdc_chan_div u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .in_lvl   (dist_lvl),
    .in_tick  (dist_rise),
    .hold     (ch_hold),
    .start_hi (start_hi),
    .dcc_on   (!dcc_off),
    .bypass   (ch_byp),
    .low_cnt  (low_cnt),
    .high_cnt (high_cnt),
    .phase    (phase),
    .div_out  (ch_out),
    .running  (ch_run)
  );

  // Forced level, then direct routing
  wire forced   = nosync && !ch_byp;
  wire div_side = forced ? force_hi : ch_out;
  wire out_d    = !direct ? div_side
                  : (rt_code == cdvdc_pkg::RT_OSC) ? osc_lvl
                  : (rt_code == cdvdc_pkg::RT_EXT) ? ext_lvl
                  : div_side;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign pair_two_output_a = out_q;
  assign pair_two_output_b = out_q;

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  wire [7:0] stat_byte = {5'h00, sdv_static, ch_run, out_q};
  wire r_cnt  = hit(araddr, cdvdc_pkg::IDX_CNT);
  wire r_ctl  = hit(araddr, cdvdc_pkg::IDX_CTL);
  wire r_rt   = hit(araddr, cdvdc_pkg::IDX_RT);
  wire r_sdv  = hit(araddr, cdvdc_pkg::IDX_SDV);
  wire r_sel  = hit(araddr, cdvdc_pkg::IDX_SEL);
  wire r_sys  = hit(araddr, cdvdc_pkg::IDX_SYS);
  wire r_upd  = hit(araddr, cdvdc_pkg::IDX_UPD);
  wire r_stat = hit(araddr, cdvdc_pkg::IDX_STAT);
  wire r_map  = r_cnt || r_ctl || r_rt || r_sdv || r_sel || r_sys
                || r_upd || r_stat;
  wire [7:0] r_byte = r_cnt  ? b_cnt_q
                    : r_ctl  ? b_ctl_q
                    : r_rt   ? b_rt_q
                    : r_sdv  ? b_sdv_q
                    : r_sel  ? b_sel_q
                    : r_sys  ? b_sys_q
                    : r_stat ? stat_byte
                    : 8'h00;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= cdvdc_pkg::RESP_OK;
      rdata_q  <= '0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= r_map ? cdvdc_pkg::RESP_OK : cdvdc_pkg::RESP_ERR;
      rdata_q  <= {24'h000000, r_byte};
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_update;
    upd ##1 1'b1;
  endsequence

  AST_UPDATE_COPY: assert property (s_update |-> a_ctl_q == $past(b_ctl_q)
    && a_sel_q == $past(b_sel_q))
    else $error("update did not copy buffer set");
  AST_NO_UPDATE: assert property (!upd |=> $stable(a_rt_q)
    && $stable(a_sdv_q))
    else $error("active set changed without update");
  AST_ROUTE_DIV: assert property (!direct |=>
    pair_two_output_a == $past(div_side))
    else $error("pair two not driven by divider");
  AST_ROUTE_OSC: assert property (direct && rt_code == cdvdc_pkg::RT_OSC
    |=> pair_two_output_b == $past(osc_lvl))
    else $error("oscillator not routed to pair two");
  AST_ROUTE_EXT: assert property (direct && rt_code == cdvdc_pkg::RT_EXT
    |=> pair_two_output_a == $past(ext_lvl))
    else $error("external clock not routed to pair two");
  AST_FORCE: assert property (nosync && !ch_byp && !direct
    |=> pair_two_output_a == $past(force_hi))
    else $error("forced level not on pair two");
  AST_SDV_STATIC: assert property (sdv_static |=> !sdv_lvl_q)
    else $error("source divider not static");
  AST_PD_SECT: assert property (pd_sect |-> !dist_lvl && ch_hold)
    else $error("clock section not powered down");
  AST_SRC_BYP: assert property (byp_eff |-> dist_lvl == src_lvl)
    else $error("source bypass not taken");

endmodule

// ---- sim/channel_divider_and_vco_divider_ctl_tb.sv ----
`timescale 1ns/1ps
module channel_divider_and_vco_divider_ctl_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        sync_n, osc_clk_in, ext_clk_in, ext_run, ext_man;
  logic        awready, wready, bvalid, arready, rvalid, out_a, out_b;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rd;
  int          fail_count, n_tests, cyc;

  // ----------------------------------------------------------------
  // Design, clock and watchdog
  // ----------------------------------------------------------------
  cdvdc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sync_n(sync_n),
    .osc_clk_in(osc_clk_in), .ext_clk_in(ext_clk_in),
    .pair_two_output_a(out_a), .pair_two_output_b(out_b));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Cuts a hang short; also drives the external clock pin, free or static
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ext_clk_in <= ext_run ? !ext_clk_in : ext_man;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [13:0] idx, input logic [7:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge aclk);
      if (awready) aw_d = 1'b1;
      if (wready) w_d = 1'b1;
      @(posedge aclk);
      if (aw_d) awvalid <= 1'b0;
      if (w_d) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    resp = bresp;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [13:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads one register and compares data and response
  task automatic chk_reg(input logic [13:0] idx, input logic [7:0] exp);
    axi_read(idx);
    chk(rd, {24'h000000, exp});
    chk({30'h0, resp}, {30'h0, cdvdc_pkg::RESP_OK});
  endtask

  // Commits buffers, lets the syncs settle, compares both pins
  task automatic upd_out(input logic exp);
    axi_write(cdvdc_pkg::IDX_UPD, 8'h01);
    repeat (10) @(posedge aclk);
    chk({31'h0, out_a}, {31'h0, exp});
    chk({31'h0, out_b}, {31'h0, exp});
  endtask

  // Commits buffers, lets the divider settle, counts high cycles on pin b
  task automatic duty(input logic [31:0] exp);
    logic [31:0] hi;
    hi = 32'h0;
    axi_write(cdvdc_pkg::IDX_UPD, 8'h01);
    repeat (40) @(posedge aclk);
    repeat (64) begin
      @(posedge aclk);
      hi = hi + {31'h0, out_b};
    end
    chk(hi, exp);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {osc_clk_in, ext_man, ext_run} = 3'h0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    sync_n = 1'b1;
    aresetn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk_reg(cdvdc_pkg::IDX_RT, 8'h00);
    chk_reg(cdvdc_pkg::IDX_CTL, 8'h00);
    chk_reg(cdvdc_pkg::IDX_SDV, 8'h02);
    chk_reg(cdvdc_pkg::IDX_SEL, 8'h00);
    $display("test reset values done");
    axi_write(cdvdc_pkg::IDX_CTL, 8'hAF);
    chk_reg(cdvdc_pkg::IDX_CTL, 8'hAF);
    axi_write(14'h0100, 8'h55);
    chk({30'h0, resp}, {30'h0, cdvdc_pkg::RESP_ERR});
    axi_read(14'h0100);
    chk(rd, 32'h00000000);
    chk({30'h0, resp}, {30'h0, cdvdc_pkg::RESP_ERR});
    $display("test access and unmapped done");
    axi_write(cdvdc_pkg::IDX_CTL, 8'h60);
    upd_out(1'b1);
    axi_write(cdvdc_pkg::IDX_CTL, 8'h40);
    upd_out(1'b0);
    ext_man <= 1'b1;
    upd_out(1'b0);
    $display("test forced level done");
    // Direct route, oscillator selected
    axi_write(cdvdc_pkg::IDX_RT, 8'h02);
    axi_write(cdvdc_pkg::IDX_SEL, 8'h02);
    ext_man <= 1'b0;
    osc_clk_in <= 1'b1;
    upd_out(1'b1);
    osc_clk_in <= 1'b0;
    ext_man <= 1'b1;
    upd_out(1'b0);
    // External clock selected
    axi_write(cdvdc_pkg::IDX_SEL, 8'h00);
    upd_out(1'b1);
    ext_man <= 1'b0;
    upd_out(1'b0);
    // Code 01b leaves the forced divider path in place
    axi_write(cdvdc_pkg::IDX_CTL, 8'h60);
    axi_write(cdvdc_pkg::IDX_SEL, 8'h01);
    upd_out(1'b1);
    $display("test direct routing done");
    for (int c = 5; c <= 7; c++) begin
      axi_write(cdvdc_pkg::IDX_SDV, 8'(c));
      axi_write(cdvdc_pkg::IDX_UPD, 8'h01);
      repeat (4) @(posedge aclk);
      axi_read(cdvdc_pkg::IDX_STAT);
      chk(rd & 32'h4, 32'h00000004);
    end
    axi_write(cdvdc_pkg::IDX_SDV, 8'h04);
    axi_write(cdvdc_pkg::IDX_UPD, 8'h01);
    repeat (4) @(posedge aclk);
    axi_read(cdvdc_pkg::IDX_STAT);
    chk(rd & 32'h4, 32'h00000000);
    chk_reg(cdvdc_pkg::IDX_UPD, 8'h00);
    $display("test source divider codes done");
    // External clock toggling, source divider bypassed, one tick per two
    ext_run <= 1'b1;
    axi_write(cdvdc_pkg::IDX_CNT, 8'h51);
    axi_write(cdvdc_pkg::IDX_RT, 8'h01);
    axi_write(cdvdc_pkg::IDX_CTL, 8'h10);
    axi_write(cdvdc_pkg::IDX_SYS, 8'h01);
    upd_out(1'b1);
    axi_write(cdvdc_pkg::IDX_CTL, 8'h00);
    upd_out(1'b0);
    // Release runs 2 ticks high, 6 low: 16 of 64 cycles high
    axi_write(cdvdc_pkg::IDX_SYS, 8'h00);
    duty(32'h10);
    // Correction on splits the 8-tick period evenly
    axi_write(cdvdc_pkg::IDX_RT, 8'h00);
    duty(32'h20);
    // Bypass passes the input through and overrides the force bit
    axi_write(cdvdc_pkg::IDX_RT, 8'h01);
    axi_write(cdvdc_pkg::IDX_CTL, 8'hE0);
    duty(32'h20);
    // Sync pin low, then section power-down, holds the divider at its start level
    axi_write(cdvdc_pkg::IDX_CTL, 8'h10);
    sync_n <= 1'b0;
    upd_out(1'b1);
    sync_n <= 1'b1;
    axi_write(cdvdc_pkg::IDX_SEL, 8'h11);
    upd_out(1'b1);
    $display("test channel divider done");
    final_report();
  end
endmodule
